/* File: design/supply_monitor_pkg.sv */
// Constants, types and field layout of the supply monitor control logic.
// Assumes the CPU reset logic reports whether a reset came from this block.
//
// What this block does
// (R1) Bit 2 selects supply comparator (0) or external sense comparator (1).
// (R2) Action bit 1 set: hold internal reset while selected input is below.
// (R3) Action bit 0: pulse interrupt on each crossing, falling and rising.
// (R4) Bit 0 reads 1 while input below threshold; 0 when above or disabled.
// (R5) Bit 7 enables the monitor and starts the comparator.
// (R6) Other resets load 82H with default start option on, else 00H.
// (R7) Monitor-caused reset keeps enable, source and action bits.
// (R8) Monitor reset in reset mode sets reset cause flag bit 0.
// (R9) Single-bit and byte writes accepted; flag bit never written.
// (R10) Software waits settling times after enabling before trusting the flag.
// (R11) During settling the flag and interrupt may change freely.
// (R12) Software stops monitor by writing 00H or clearing the enable bit.
// (R13) Disabling in interrupt mode while below may raise an interrupt.
// (R14) Sixteen threshold levels; level code forwarded to the reference.
// (R15) Level register resets to 0EH except on a monitor-caused reset.
// (R16) Software sets the sense pin direction bit to input before use.
// (R17) Control bits 6 to 3 read zero and ignore writes.
// (R18) Comparator outputs are synchronised before any use.
package supply_monitor_pkg;

  localparam logic [19:0] CTRL_ADDR = 20'hfffa9;
  localparam logic [19:0] LEVEL_ADDR = 20'hfffaa;

  localparam int ENABLE_BIT = 7;
  localparam int SOURCE_BIT = 2;
  localparam int ACTION_BIT = 1;
  localparam int FLAG_BIT = 0;
  localparam int CAUSE_BIT = 0;

  localparam logic [7:0] CTRL_WRITE_MASK = 8'h86;
  localparam logic [7:0] CTRL_RESET_START = 8'h82;
  localparam logic [7:0] CTRL_RESET_OFF = 8'h00;
  localparam logic [3:0] LEVEL_RESET = 4'he;

  typedef struct packed {
    logic wr;
    logic bit_wr;
    logic [2:0] bit_idx;
    logic [19:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic below;
    logic rise_edge;
    logic fall_edge;
  } cmp_state_t;

endpackage : supply_monitor_pkg

/* File: design/cmp_sync.sv */
// Two-stage synchroniser with edge detection for one comparator output.
// Assumes the comparator output is asynchronous to clk.
`timescale 1ns/1ps
module cmp_sync
  import supply_monitor_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous level
  input wire logic async_in,
  // Synchronised result
  output cmp_state_t state
);

  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic last_q, last_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
    last_d = sync_q;
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= meta_d; // R18
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign state = '{below: sync_q,
                   rise_edge: ~sync_q & last_q,
                   fall_edge: sync_q & ~last_q};

  stage_follow_a: assert property (@(posedge clk) disable iff (rst) // R18
    $rose(meta_q) |=> sync_q) else $error("sync stage did not follow");

endmodule : cmp_sync

/* File: design/supply_monitor.sv */
// Supply monitor control: source select, reset or interrupt action,
// control and level registers on the CPU internal bus.
// Assumes the CPU reset logic tells whether the last reset was ours.
`timescale 1ns/1ps
module supply_monitor
  import supply_monitor_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic rst_by_monitor,
  input wire logic default_start_off,
  // Internal bus
  input reg_req_t bus_req,
  output logic [7:0] bus_rdata,
  // Analog side
  input wire logic supply_below,
  input wire logic ext_sense_pin_below,
  output logic cmp_enable,
  output logic [3:0] threshold_level,
  // Reset and interrupt
  output logic monitor_reset,
  output logic monitor_irq,
  output logic monitor_reset_cause_flag
);

  // ----------------------------------------------------------------
  // Comparator synchronisers
  // ----------------------------------------------------------------
  cmp_state_t sup_s, ext_s, sel_s;

  cmp_sync u_sup (
    .clk(clk),
    .rst(rst),
    .async_in(supply_below),
    .state(sup_s)
  );

  cmp_sync u_ext (
    .clk(clk),
    .rst(rst),
    .async_in(ext_sense_pin_below),
    .state(ext_s)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q, ctrl_d;
  logic [3:0] level_q, level_d;
  logic cause_q, cause_d;
  logic was_on_q, was_on_d;
  logic flag;
  logic ctrl_hit, level_hit;
  logic [7:0] level_merged;

  // Changing source gives no crossing pulse; only edges seen by the
  // chosen comparator's own synchroniser are reported
  assign sel_s = ctrl_q[SOURCE_BIT] ? ext_s : sup_s; // R1

  function automatic logic [7:0] merge_write(input logic [7:0] old,
                                             input reg_req_t req);
    logic [7:0] nv;
    nv = old;
    if (req.bit_wr)
      nv[req.bit_idx] = req.wdata[0];
    else
      nv = req.wdata;
    return nv;
  endfunction : merge_write

  // One decode serves both the write strobe and the read mux
  function automatic logic addr_is(input reg_req_t req,
                                   input logic [19:0] target);
    return req.addr == target;
  endfunction : addr_is

  assign ctrl_hit = bus_req.wr && addr_is(bus_req, CTRL_ADDR);
  assign level_hit = bus_req.wr && addr_is(bus_req, LEVEL_ADDR);
  // Only the low nibble is stored, so upper write bits fall away when level_d takes level_merged[3:0]
  assign level_merged = merge_write({4'h0, level_q}, bus_req);
  assign flag = ctrl_q[ENABLE_BIT] & sel_s.below; // R4 R11

  always_comb begin
    ctrl_d = ctrl_q;
    level_d = level_q;
    cause_d = cause_q;
    was_on_d = ctrl_q[ENABLE_BIT];
    // Flag and unused bits never reach storage; reads rebuild the flag
    // from the live comparator so it cannot go stale
    if (ctrl_hit)
      ctrl_d = merge_write(ctrl_q, bus_req) & CTRL_WRITE_MASK; // R9 R17
    if (level_hit)
      level_d = level_merged[3:0]; // R14
    if (monitor_reset)
      cause_d = 1'b1; // R8
  end

  // Monitor reset keeps mode bits; others reload from the option
  always_ff @(posedge clk) begin
    if (rst && !rst_by_monitor) begin
      ctrl_q <= default_start_off ? CTRL_RESET_OFF : CTRL_RESET_START; // R6 R7
      level_q <= LEVEL_RESET; // R15
      cause_q <= 1'b0;
      was_on_q <= 1'b0;
    end else if (rst) begin
      ctrl_q <= ctrl_q; // R7
      level_q <= level_q; // R15
      cause_q <= 1'b1; // R8
      was_on_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      level_q <= level_d;
      cause_q <= cause_d;
      was_on_q <= was_on_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic irq_q, irq_d;
  logic rst_q, rst_d;
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    // Falling enable in interrupt mode while below also reports
    irq_d = !ctrl_q[ACTION_BIT] &&
            ((ctrl_q[ENABLE_BIT] && (sel_s.fall_edge || sel_s.rise_edge)) ||
             (was_on_q && !ctrl_q[ENABLE_BIT] && sel_s.below)); // R3 R13
    // A level, not a pulse: the reset logic holds reset while below
    // and lets go once the synchronised input is back at or above
    rst_d = ctrl_q[ENABLE_BIT] && ctrl_q[ACTION_BIT] && sel_s.below; // R2 R5
    rdata_d = 8'h00;
    if (addr_is(bus_req, CTRL_ADDR))
      rdata_d = (ctrl_q & CTRL_WRITE_MASK) | {7'h00, flag}; // R4 R17
    else if (addr_is(bus_req, LEVEL_ADDR))
      rdata_d = {4'h0, level_q};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q <= 1'b0;
      rst_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      irq_q <= irq_d;
      rst_q <= rst_d;
      rdata_q <= rdata_d;
    end
  end

  assign monitor_irq = irq_q;
  assign monitor_reset = rst_q;
  assign bus_rdata = rdata_q;
  assign cmp_enable = ctrl_q[ENABLE_BIT]; // R5
  assign threshold_level = level_q; // R14
  assign monitor_reset_cause_flag = cause_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Sequences name the trigger conditions, each used by a single check
  sequence below_in_reset_mode;
    ctrl_q[ENABLE_BIT] && ctrl_q[ACTION_BIT] && sel_s.below;
  endsequence

  sequence off_in_irq_mode_below;
    $fell(ctrl_q[ENABLE_BIT]) && !ctrl_q[ACTION_BIT] && sel_s.below;
  endsequence

  sequence crossing_in_irq_mode;
    ctrl_q[ENABLE_BIT] && !ctrl_q[ACTION_BIT] &&
    (sel_s.fall_edge || sel_s.rise_edge);
  endsequence

  reset_hold_a: assert property (@(posedge clk) disable iff (rst) // R2
    below_in_reset_mode |=> monitor_reset) else $error("no reset");
  reset_free_a: assert property (@(posedge clk) disable iff (rst) // R2
    !(ctrl_q[ENABLE_BIT] && ctrl_q[ACTION_BIT] && sel_s.below)
    |=> !monitor_reset) else $error("reset not released");
  reset_only_a: assert property (@(posedge clk) disable iff (rst) // R2
    monitor_reset |-> $past(ctrl_q[ACTION_BIT])) else $error("bad reset");
  irq_edge_a: assert property (@(posedge clk) disable iff (rst) // R3
    crossing_in_irq_mode |=> monitor_irq) else $error("missed irq");
  irq_mode_a: assert property (@(posedge clk) disable iff (rst) // R3
    monitor_irq |-> !$past(ctrl_q[ACTION_BIT])) else $error("irq in reset");
  irq_off_a: assert property (@(posedge clk) disable iff (rst) // R13
    off_in_irq_mode_below |=> monitor_irq) else $error("no irq on stop");
  flag_off_a: assert property (@(posedge clk) disable iff (rst) // R4
    !ctrl_q[ENABLE_BIT] |-> !flag) else $error("flag while off");
  flag_read_a: assert property (@(posedge clk) disable iff (rst) // R4
    (bus_req.addr == CTRL_ADDR) |=> bus_rdata[FLAG_BIT] == $past(flag))
    else $error("flag read");
  zero_bits_a: assert property (@(posedge clk) disable iff (rst) // R17
    ctrl_q[6:3] == 4'h0 && !ctrl_q[FLAG_BIT]) else $error("reserved bits");
  bit_write_a: assert property (@(posedge clk) disable iff (rst) // R9
    (ctrl_hit && bus_req.bit_wr && bus_req.bit_idx == 3'(ENABLE_BIT))
    |=> cmp_enable == $past(bus_req.wdata[0])) else $error("bit write");
  cause_set_a: assert property (@(posedge clk) disable iff (rst) // R8
    monitor_reset |=> monitor_reset_cause_flag) else $error("no cause");
  cause_hold_a: assert property (@(posedge clk) // R8
    disable iff (rst && !rst_by_monitor)
    monitor_reset_cause_flag |=> monitor_reset_cause_flag)
    else $error("cause lost");
  cmp_on_a: assert property (@(posedge clk) disable iff (rst) // R5
    (ctrl_hit && !bus_req.bit_wr) |=>
    cmp_enable == $past(bus_req.wdata[ENABLE_BIT]))
    else $error("cmp enable");
  level_write_a: assert property (@(posedge clk) disable iff (rst) // R14
    (level_hit && !bus_req.bit_wr) |=>
    threshold_level == $past(bus_req.wdata[3:0])) else $error("level write");
  src_sel_a: assert property (@(posedge clk) disable iff (rst) // R1
    ctrl_q[SOURCE_BIT] |-> sel_s == ext_s) else $error("wrong source");
  src_supply_a: assert property (@(posedge clk) disable iff (rst) // R1
    !ctrl_q[SOURCE_BIT] |-> sel_s == sup_s) else $error("wrong supply");
  keep_mode_a: assert property (@(posedge clk) // R7
    (rst && rst_by_monitor) |=> $stable(ctrl_q)) else $error("mode lost");
  level_rst_a: assert property (@(posedge clk) // R15
    (rst && !rst_by_monitor) |=> level_q == LEVEL_RESET)
    else $error("level reset");
  ctrl_rst_a: assert property (@(posedge clk) // R6
    (rst && !rst_by_monitor) |=> ctrl_q == ($past(default_start_off) ?
    CTRL_RESET_OFF : CTRL_RESET_START)) else $error("control reset");

endmodule : supply_monitor

/* File: sim/analog_cmp_model.sv */
// Behavioural comparators that face the supply monitor.
// Assumes the bench sets each analog level as a plain bit.
`timescale 1ns/1ps
module analog_cmp_model (
  // Commanded levels
  input wire logic supply_low,
  input wire logic sense_low,
  // Comparator outputs
  output logic supply_below,
  output logic ext_sense_pin_below
);
  // Odd delays keep the edges off the clock grid, as a real comparator would
  assign #3.3 supply_below = supply_low;
  assign #5.1 ext_sense_pin_below = sense_low;
endmodule : analog_cmp_model

/* File: sim/test_supply_monitor.sv */
// Self-checking bench for the supply monitor control logic.
// Assumes analog_cmp_model stands in for the comparators.
`timescale 1ns/1ps
module test_supply_monitor;
  import supply_monitor_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rst_by_monitor = 1'b0;
  logic default_start_off = 1'b0;
  reg_req_t bus_req = '0;
  logic supply_low = 1'b0;
  logic sense_low = 1'b0;
  logic [7:0] bus_rdata;
  logic [3:0] threshold_level;
  logic supply_below, ext_sense_pin_below, cmp_enable;
  logic monitor_reset, monitor_irq, monitor_reset_cause_flag;
  int fails = 0;
  int compares = 0;
  int irqs = 0;
  int base = 0;
  int cycles = 0;

  supply_monitor dut_u (.clk(clk), .rst(rst), .rst_by_monitor(rst_by_monitor),
    .default_start_off(default_start_off), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .supply_below(supply_below),
    .ext_sense_pin_below(ext_sense_pin_below), .cmp_enable(cmp_enable),
    .threshold_level(threshold_level), .monitor_reset(monitor_reset),
    .monitor_irq(monitor_irq),
    .monitor_reset_cause_flag(monitor_reset_cause_flag));
  analog_cmp_model cmp_u (.supply_low(supply_low), .sense_low(sense_low),
    .supply_below(supply_below), .ext_sense_pin_below(ext_sense_pin_below));

  initial begin
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (monitor_irq === 1'b1) irqs <= irqs + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      end_sim();
    end
  end

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [19:0] a, input logic [7:0] d,
                    input logic bw, input logic [2:0] idx);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, bit_wr: bw, bit_idx: idx, addr: a, wdata: d};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_req.addr <= a;
    @(posedge clk);
    @(negedge clk);
    chk(bus_rdata, exp);
  endtask : rd

  // Sync plus output stage is 3 cycles; settling time is scaled down
  task automatic settle();
    repeat (8) @(negedge clk);
  endtask : settle

  task automatic do_rst(input logic by_mon, input logic off);
    @(posedge clk);
    rst <= 1'b1;
    rst_by_monitor <= by_mon;
    default_start_off <= off;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rst_by_monitor <= 1'b0;
  endtask : do_rst

  task automatic end_sim();
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(CTRL_ADDR, 8'h82);
    rd(LEVEL_ADDR, 8'h0e);
    rd(20'hfffab, 8'h00);
    wr(LEVEL_ADDR, 8'hff, 1'b0, 3'h0);
    @(negedge clk);
    chk(8'(threshold_level), 8'h0f);
    wr(CTRL_ADDR, 8'hff, 1'b0, 3'h0);
    settle();
    rd(CTRL_ADDR, 8'h86);
    supply_low <= 1'b1;
    settle();
    chk(8'(monitor_reset), 8'h00);
    sense_low <= 1'b1;
    settle();
    chk(8'(monitor_reset), 8'h01);
    rd(CTRL_ADDR, 8'h87);
    do_rst(1'b1, 1'b1);
    settle();
    chk(8'(monitor_reset_cause_flag), 8'h01);
    rd(CTRL_ADDR, 8'h87);
    rd(LEVEL_ADDR, 8'h0f);
    sense_low <= 1'b0;
    settle();
    chk(8'(monitor_reset), 8'h00);
    do_rst(1'b0, 1'b1);
    settle();
    chk(8'(monitor_reset_cause_flag), 8'h00);
    rd(CTRL_ADDR, 8'h00);
    rd(LEVEL_ADDR, 8'h0e);
    // Raise the supply just before enabling; its crossing still pulses an interrupt before base is taken
    supply_low <= 1'b0;
    wr(CTRL_ADDR, 8'h80, 1'b0, 3'h0);
    settle();
    chk(8'(cmp_enable), 8'h01);
    base = irqs;
    supply_low <= 1'b1;
    settle();
    chk(8'(monitor_reset), 8'h00);
    rd(CTRL_ADDR, 8'h81);
    supply_low <= 1'b0;
    settle();
    chk(8'(irqs - base), 8'h02);
    supply_low <= 1'b1;
    settle();
    wr(CTRL_ADDR, 8'h00, 1'b1, 3'h7);
    settle();
    chk(8'(irqs - base), 8'h04);
    chk(8'(cmp_enable), 8'h00);
    rd(CTRL_ADDR, 8'h00);
    end_sim();
  end
endmodule : test_supply_monitor
